// [rtl/fault_supervisor.sv]
// Module: countdown watchdog with APB control register and reset pin drive
// Behaviour
// - Count decrements once every 49,152 cycles.
// - Active and 40h to 3Fh starts reset.
// - Count keeps decrementing while not activated.
// - Reset leaves it inactive; active stays active.
// - Activate set, top bit clear: immediate reset.
// - Activate bit set by software, cleared by reset.
// - Hardware option forces watchdog always active.
// - Reset-on-halt option and active: halt resets.
// - Otherwise halt stops counting and reset generation.
// - External wake resumes counting after 4096 clocks.
// - Control register resets to 7Fh.
// - Bit 7 activate, bits 6:0 count, read/write.
`timescale 1ns/100ps
module fault_supervisor
	import fault_supervisor_pkg::*;
#(
	parameter int TICK_LEN  = TICK_CYCLES,
	parameter int PULSE_LEN = RESET_PULSE_WIDTH
) (
	// Clock and reset
	input  wire logic     pclk,
	input  wire logic     presetn,
	// APB slave
	input  wire apb_req_s apb_req,
	output apb_rsp_s      apb_rsp,
	// Option byte settings, from outside the clock domain
	input  wire logic     hw_watchdog_opt,
	input  wire logic     halt_reset_opt,
	// CPU low power events, one-cycle pulses on pclk
	input  wire logic     halt_exec,
	input  wire logic     ext_wake,
	// Reset pin, open drain
	output logic          reset_pin_o,
	output logic          reset_pin_oe
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                watchdog_activate;
		logic [COUNT_W-1:0]  count;
		logic [15:0]         presc;
		mode_e               mode;
		logic [11:0]         wake_cnt;
		logic [15:0]         pulse_cnt;
		logic [2:0]          hw_sync;
		logic [2:0]          halt_sync;
		logic                hw_opt;
		logic                halt_opt;
		apb_rsp_s            rsp;
		logic                pin_oe;
		logic                pin_o;
	} state_s;

	state_s st;
	state_s next_st;

	localparam logic [15:0] TICK_RELOAD  = 16'(TICK_LEN - 1);
	localparam logic [15:0] PULSE_RELOAD = 16'(PULSE_LEN - 1);
	localparam logic [11:0] WAKE_RELOAD  = 12'(WAKE_DELAY_CLOCKS - 1);

	function automatic logic hits_control(input logic [11:0] addr);
		hits_control = (addr[11:2] == WATCHDOG_CONTROL_OFFSET[11:2]);
	endfunction

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic active;
	logic wr;
	logic tick;
	logic counting;
	logic setup;

	assign active   = st.watchdog_activate | st.hw_opt;
	assign setup    = apb_req.psel & ~apb_req.penable;
	// Write lands only at the edge where the access phase sees pready
	assign wr       = apb_req.psel & apb_req.penable & st.rsp.pready & apb_req.pwrite
		& hits_control(apb_req.paddr) & apb_req.pstrb[0];
	assign counting = (st.mode == MODE_RUN) | (st.mode == MODE_PULSE);
	assign tick     = counting & (st.presc == 16'h0000);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;

		// Option inputs: a change counts once stages two and three agree
		next_st.hw_sync   = {st.hw_sync[1:0], hw_watchdog_opt};
		next_st.halt_sync = {st.halt_sync[1:0], halt_reset_opt};
		if (st.hw_sync[2] == st.hw_sync[1]) begin
			next_st.hw_opt = st.hw_sync[2];
		end
		if (st.halt_sync[2] == st.halt_sync[1]) begin
			next_st.halt_opt = st.halt_sync[2];
		end

		// Prescaler stops with the oscillator in halt
		if (counting) begin
			next_st.presc = tick ? TICK_RELOAD : st.presc - 16'h0001;
		end

		// Free running down count, active or not
		if (tick) begin
			next_st.count = st.count - 7'h01;
		end

		// APB answer: zero wait states, registered at setup
		next_st.rsp.pready  = setup;
		next_st.rsp.pslverr = setup & ~hits_control(apb_req.paddr);
		next_st.rsp.prdata  = '0;
		if (setup && !apb_req.pwrite && hits_control(apb_req.paddr)) begin
			next_st.rsp.prdata[7:0] = {st.watchdog_activate, st.count};
		end

		// A refresh written in the tick cycle wins over the decrement
		if (wr) begin
			next_st.watchdog_activate = st.watchdog_activate | apb_req.pwdata[ACTIVATE_BIT];
			next_st.count             = apb_req.pwdata[COUNT_W-1:0];
		end

		unique case (st.mode)
			MODE_RUN: begin
				if (wr && apb_req.pwdata[ACTIVATE_BIT] && !apb_req.pwdata[COUNT_TOP_BIT]) begin
					next_st.mode = MODE_PULSE;
				end else if (active && tick && !wr && st.count == COUNT_EXPIRE) begin
					next_st.mode = MODE_PULSE;
				end else if (halt_exec && st.halt_opt && active) begin
					next_st.mode = MODE_PULSE;
				end else if (halt_exec) begin
					next_st.mode = MODE_HALT;
				end
				if (next_st.mode == MODE_PULSE) begin
					next_st.pin_oe    = 1'b1;
					next_st.pulse_cnt = PULSE_RELOAD;
				end
			end
			MODE_HALT: begin
				// No count and no reset until woken
				if (ext_wake) begin
					next_st.mode     = MODE_WAKE;
					next_st.wake_cnt = WAKE_RELOAD;
				end
			end
			MODE_WAKE: begin
				if (st.wake_cnt == 12'h000) begin
					next_st.mode = MODE_RUN;
				end else begin
					next_st.wake_cnt = st.wake_cnt - 12'h001;
				end
			end
			MODE_PULSE: begin
				// Pin held low for PULSE_LEN cycles, the system reset follows its release
				if (st.pulse_cnt == 16'h0000) begin
					next_st.pin_oe = 1'b0;
					next_st.mode   = MODE_RUN;
				end else begin
					next_st.pulse_cnt = st.pulse_cnt - 16'h0001;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			next_st_reset: begin
				st                   <= '0;
				st.watchdog_activate <= WATCHDOG_CONTROL_RESET[ACTIVATE_BIT];
				st.count             <= COUNT_RESET;
				st.presc             <= TICK_RELOAD;
				st.mode              <= MODE_RUN;
			end
		end else begin
			st <= next_st;
		end
	end

	assign apb_rsp      = st.rsp;
	assign reset_pin_oe = st.pin_oe;
	// Open drain: the level flop resets to zero and never leaves it, the pin only ever pulls low
	assign reset_pin_o  = st.pin_o;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_tick_decrement;
		tick && !wr |=> st.count == 7'($past(st.count) - 7'h01);
	endproperty
	a_tick_decrement: assert property (p_tick_decrement) else $error("count did not step on tick");

	property p_tick_spacing;
		tick |=> !tick [*8];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("ticks too close");

	property p_expire;
		active && tick && !wr && st.count == COUNT_EXPIRE && st.mode == MODE_RUN
			|=> st.mode == MODE_PULSE && reset_pin_oe;
	endproperty
	a_expire: assert property (p_expire) else $error("no reset on expiry");

	property p_free_run;
		!active && tick && !wr |=> st.count != $past(st.count) && !reset_pin_oe;
	endproperty
	a_free_run: assert property (p_free_run) else $error("inactive count wrong");

	property p_sticky_activate;
		st.watchdog_activate |=> st.watchdog_activate;
	endproperty
	a_sticky_activate: assert property (p_sticky_activate) else $error("activate bit cleared");

	property p_soft_reset;
		wr && apb_req.pwdata[7:6] == 2'b10 && st.mode == MODE_RUN |=> reset_pin_oe;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("software reset missed");

	property p_hw_option;
		st.hw_opt && tick && !wr && st.count == COUNT_EXPIRE && st.mode == MODE_RUN |=> reset_pin_oe;
	endproperty
	a_hw_option: assert property (p_hw_option) else $error("hardware option not active");

	property p_halt_reset;
		halt_exec && st.halt_opt && active && st.mode == MODE_RUN && !wr && !tick |=> reset_pin_oe;
	endproperty
	a_halt_reset: assert property (p_halt_reset) else $error("halt did not reset");

	property p_halt_frozen;
		st.mode == MODE_HALT && !wr |=> $stable(st.count) && !reset_pin_oe;
	endproperty
	a_halt_frozen: assert property (p_halt_frozen) else $error("count moved in halt");

	property p_wake_delay;
		st.mode == MODE_HALT && ext_wake |=> st.mode == MODE_WAKE [*8] ##1 !tick;
	endproperty
	a_wake_delay: assert property (p_wake_delay) else $error("woke too early");

	property p_read_back;
		setup && !apb_req.pwrite && hits_control(apb_req.paddr)
			|=> apb_rsp.pready && apb_rsp.prdata[7:0] == $past({st.watchdog_activate, st.count});
	endproperty
	a_read_back: assert property (p_read_back) else $error("read data wrong");

	property p_pulse_hold;
		reset_pin_oe && st.pulse_cnt != 16'h0000 |=> reset_pin_oe;
	endproperty
	a_pulse_hold: assert property (p_pulse_hold) else $error("reset pulse cut short");

	property p_pulse_start;
		$rose(reset_pin_oe) |-> st.pulse_cnt == PULSE_RELOAD;
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("pulse length not loaded");

	property p_pulse_end;
		reset_pin_oe && st.pulse_cnt == 16'h0000 |=> !reset_pin_oe;
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("reset pulse too long");

	property p_no_spurious;
		!reset_pin_oe && st.mode == MODE_RUN && !wr && !halt_exec && !tick |=> !reset_pin_oe;
	endproperty
	a_no_spurious: assert property (p_no_spurious) else $error("reset pin pulled without cause");

	property p_inactive_expire;
		!active && tick && !wr && st.count == COUNT_EXPIRE && st.mode == MODE_RUN |=> !reset_pin_oe;
	endproperty
	a_inactive_expire: assert property (p_inactive_expire) else $error("inactive watchdog reset");

	property p_tick_reload;
		tick |=> st.presc == TICK_RELOAD;
	endproperty
	a_tick_reload: assert property (p_tick_reload) else $error("prescaler not reloaded");

	// ----------------------------------------------------------------
	// Assertions: register bus
	// ----------------------------------------------------------------
	property p_write_lands;
		wr |=> st.count == $past(apb_req.pwdata[COUNT_W-1:0]);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("count write lost");

	property p_activate_set;
		wr && apb_req.pwdata[ACTIVATE_BIT] |=> st.watchdog_activate;
	endproperty
	a_activate_set: assert property (p_activate_set) else $error("activate bit not set");

	property p_pready_pulse;
		apb_rsp.pready |=> !apb_rsp.pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) else $error("ready held too long");

	property p_unmapped;
		setup && !hits_control(apb_req.paddr)
			|=> apb_rsp.pready && apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

	property p_high_bytes;
		apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h00_0000;
	endproperty
	a_high_bytes: assert property (p_high_bytes) else $error("upper read bytes not zero");

	// ----------------------------------------------------------------
	// Assertions: low power
	// ----------------------------------------------------------------
	property p_halt_entry;
		halt_exec && !st.halt_opt && st.mode == MODE_RUN && !wr && !tick |=> st.mode == MODE_HALT;
	endproperty
	a_halt_entry: assert property (p_halt_entry) else $error("halt not entered");

	property p_halt_inactive;
		halt_exec && !active && st.mode == MODE_RUN && !wr && !tick |=> st.mode == MODE_HALT && !reset_pin_oe;
	endproperty
	a_halt_inactive: assert property (p_halt_inactive) else $error("inactive halt reset");

	property p_presc_frozen;
		st.mode == MODE_HALT |=> $stable(st.presc);
	endproperty
	a_presc_frozen: assert property (p_presc_frozen) else $error("prescaler ran in halt");

	property p_wake_hold;
		st.mode == MODE_WAKE && st.wake_cnt != 12'h000 |=> st.mode == MODE_WAKE && $stable(st.presc);
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("counting during wake delay");

	property p_wake_resume;
		st.mode == MODE_WAKE && st.wake_cnt == 12'h000 |=> st.mode == MODE_RUN;
	endproperty
	a_wake_resume: assert property (p_wake_resume) else $error("counting did not resume");

	c_expire:     cover property (active && tick && st.count == COUNT_EXPIRE);
	c_halt:       cover property (st.mode == MODE_HALT ##1 st.mode == MODE_WAKE);
	c_soft_reset: cover property (wr && apb_req.pwdata[7:6] == 2'b10);
	c_wake:       cover property (st.mode == MODE_WAKE ##1 st.mode == MODE_RUN);
	c_refresh:    cover property (wr && apb_req.pwdata[7:6] == 2'b11);

endmodule

// [rtl/fault_supervisor_pkg.sv]
// Package: register map, reset values, timing counts and carriers of the watchdog
package fault_supervisor_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] WATCHDOG_CONTROL_OFFSET = 12'h00c;
	localparam logic [7:0]  WATCHDOG_CONTROL_RESET  = 8'h7f;
	localparam int          ACTIVATE_BIT            = 7;
	localparam int          COUNT_TOP_BIT           = 6;
	localparam int          COUNT_W                 = 7;
	localparam logic [6:0]  COUNT_RESET             = 7'h7f;
	localparam logic [6:0]  COUNT_EXPIRE            = 7'h40;

	// ----------------------------------------------------------------
	// Timing counts, in pclk cycles
	// ----------------------------------------------------------------
	localparam int TICK_CYCLES        = 49152;
	localparam int WAKE_DELAY_CLOCKS  = 4096;
	localparam int RESET_PULSE_WIDTH  = 64;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

	typedef enum logic [1:0] {
		MODE_RUN   = 2'b00,
		MODE_HALT  = 2'b01,
		MODE_WAKE  = 2'b10,
		MODE_PULSE = 2'b11
	} mode_e;

endpackage

// [verif/reset_line_model.sv]
// Model of the reset circuit that sits behind the open-drain reset pin
`timescale 1ns/100ps
module reset_line_model (
	// Clock and power-on reset
	input  wire logic pclk,
	input  wire logic por_n,
	// Reset pin
	input  wire logic reset_pin_o,
	input  wire logic reset_pin_oe,
	// System reset
	output logic      presetn
);
	logic pin;
	logic pin_d;
	// Pull-up holds the pin high when nobody drives it
	assign pin = reset_pin_oe ? reset_pin_o : 1'b1;
	// Reset follows the end of the low pulse, so the pulse is never cut short
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			pin_d   <= 1'b1;
			presetn <= 1'b0;
		end else begin
			pin_d   <= pin;
			presetn <= !(pin && !pin_d);
		end
	end
endmodule

// [verif/fault_supervisor_test.sv]
// Self-checking bench for the watchdog: register, countdown, expiry, soft reset, options, halt
`timescale 1ns/100ps
module fault_supervisor_test;
	import fault_supervisor_pkg::*;
	localparam int TL = 16;
	localparam int PL = 4;
	logic     pclk, por_n, presetn, hw, hro, hx, xw, po, oe;
	apb_req_s req;
	apb_rsp_s rsp;
	int       mismatches, n_checks;
	logic [7:0] r, r2;
	logic       e;
	int         k;

	fault_supervisor #(.TICK_LEN(TL), .PULSE_LEN(PL)) fault_supervisor_i (.pclk(pclk), .presetn(presetn),
		.apb_req(req), .apb_rsp(rsp), .hw_watchdog_opt(hw), .halt_reset_opt(hro), .halt_exec(hx),
		.ext_wake(xw), .reset_pin_o(po), .reset_pin_oe(oe));
	reset_line_model reset_line_model_i (.pclk(pclk), .por_n(por_n), .reset_pin_o(po),
		.reset_pin_oe(oe), .presetn(presetn));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ap(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk) req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}, pstrb: 4'hf};
		@(posedge pclk) req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		r = rsp.prdata[7:0];
		e = rsp.pslverr;
		req <= '0;
	endtask
	// Waits at falling edges, where the pin enable has settled
	task automatic wait_oe(input int lim);
		k = 0;
		while (oe !== 1'b1 && k < lim) begin
			@(negedge pclk);
			k++;
		end
	endtask
	task automatic width_and_recover();
		k = 0;
		while (oe === 1'b1 && k < 100) begin
			@(negedge pclk);
			k++;
		end
		chk(k, PL);
		repeat (6) @(posedge pclk);
	endtask
	task automatic halt_pulse(input logic wake);
		@(posedge pclk) if (wake) xw <= 1'b1; else hx <= 1'b1;
		@(posedge pclk) begin
			xw <= 1'b0;
			hx <= 1'b0;
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_count();
		ap(0, WATCHDOG_CONTROL_OFFSET, 8'h00);
		chk(r, WATCHDOG_CONTROL_RESET);
		r2 = r;
		repeat (29) @(posedge pclk);
		ap(0, WATCHDOG_CONTROL_OFFSET, 8'h00);
		chk(r, WATCHDOG_CONTROL_RESET - 8'h02);
		ap(0, 12'h010, 8'h00);
		chk({r, e}, 9'h001);
		$display("test count done");
	endtask
	task automatic t_expiry();
		ap(1, WATCHDOG_CONTROL_OFFSET, 8'hc1);
		ap(1, WATCHDOG_CONTROL_OFFSET, 8'h41);
		ap(0, WATCHDOG_CONTROL_OFFSET, 8'h00);
		chk(r[7], 1'b1);
		wait_oe(3 * TL);
		chk({oe, po}, 2'b10);
		width_and_recover();
		ap(0, WATCHDOG_CONTROL_OFFSET, 8'h00);
		chk(r, 8'h7f);
		$display("test expiry done");
	endtask
	task automatic t_soft();
		ap(1, WATCHDOG_CONTROL_OFFSET, 8'h80);
		wait_oe(2);
		chk(oe, 1'b1);
		width_and_recover();
		$display("test soft reset done");
	endtask
	task automatic t_hw();
		hw <= 1'b1;
		repeat (5) @(posedge pclk);
		ap(1, WATCHDOG_CONTROL_OFFSET, 8'h41);
		wait_oe(3 * TL);
		chk(oe, 1'b1);
		@(posedge pclk) hw <= 1'b0;
		width_and_recover();
		$display("test hardware option done");
	endtask
	task automatic t_halt_reset();
		hro <= 1'b1;
		repeat (5) @(posedge pclk);
		ap(1, WATCHDOG_CONTROL_OFFSET, 8'hff);
		halt_pulse(0);
		wait_oe(2);
		chk(oe, 1'b1);
		@(posedge pclk) hro <= 1'b0;
		width_and_recover();
		$display("test halt reset done");
	endtask
	task automatic t_sleep();
		ap(1, WATCHDOG_CONTROL_OFFSET, 8'hc2);
		halt_pulse(0);
		ap(0, WATCHDOG_CONTROL_OFFSET, 8'h00);
		r2 = r;
		wait_oe(8 * TL);
		ap(0, WATCHDOG_CONTROL_OFFSET, 8'h00);
		chk({oe, r}, {1'b0, r2});
		halt_pulse(1);
		wait_oe(WAKE_DELAY_CLOCKS - 8);
		chk(oe, 1'b0);
		wait_oe(5 * TL);
		chk(oe, 1'b1);
		width_and_recover();
		$display("test halt sleep done");
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #20 pclk = !pclk;
	end
	initial begin
		#(40 * 20000);
		mismatches++;
		results();
	end
	initial begin
		{por_n, hw, hro, hx, xw, req, mismatches, n_checks} = '0;
		repeat (10) @(posedge pclk);
		por_n <= 1'b1;
		@(posedge pclk);
		t_count();
		t_expiry();
		t_soft();
		t_hw();
		t_halt_reset();
		t_sleep();
		results();
	end
endmodule
